// File: psp_pkg.sv
// Purpose: shared constants and carriers for the pipelined sram port control block
// Assumes: one clock, bus pins synchronous to it, no software registers
// Notes on behaviour
// - third chip select, active low, sampled each qualified load edge for selection
// - data pins drive only while async output enable is low, else inputs
// - output enable ignored in write data cycle, first cycle after deselect, deselected
// - edges act only while clock qualify is low; otherwise nothing but the strap captured
// - clock qualify high stretches the cycle, never deselects
// - data pins acting as inputs are captured on the rising edge
// - read data driven one cycle after the edge that sampled its address
// - outputs tri-stated in write data cycle, after deselect and while deselected
// - each parity lane behaves as a data lane under its byte write select
// - strap high gives interleaved burst order, low gives linear order
// - unconnected strap behaves as high, interleaved order
// - advance-or-load high advances burst counter, low loads a new address
// - byte lane written only with write strobe low at its access's load edge and its lane select low at that beat's load or advance edge
`default_nettype none

package psp_pkg;

    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int DATA_W = LANES * LANE_W;
    localparam int BURST_W = 2;
    localparam int SYNC_STAGES = 2;

    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
    localparam logic [LANES-1:0] LANE_N_RST = 4'hF;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
    localparam logic [LANES-1:0] PAR_RST = 4'h0;
    // interleaved is the safe default until the strap has been sampled
    localparam logic MODE_RST = 1'h1;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_wr_n;
    } psp_cmd_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] par;
    } psp_word_s;

    typedef struct packed {
        logic chip_select_low_a;
        logic chip_select_high;
        logic chip_select_low_c;
        logic clock_qualify_n;
        logic write_n;
        logic advance_or_load;
        logic [LANES-1:0] byte_lane_write_n;
        logic [ADDR_W-1:0] addr;
    } psp_ctrl_s;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] mode_sync;
        logic mode;
        psp_cmd_s stage1;
        psp_cmd_s stage2;
        logic [BURST_W-1:0] burst_start;
        logic [BURST_W-1:0] burst_count;
        psp_word_s rd_word;
    } psp_state_s;

endpackage : psp_pkg

`default_nettype wire

// File: psp_burst_step.sv
// Purpose: low address bits of the next beat of a burst
// Assumes: count is the beat number already advanced by the caller
// Notes: pure combinational, no state
`default_nettype none

module psp_burst_step
(
    // burst position
    input wire logic [psp_pkg::BURST_W-1:0] i_start,
    input wire logic [psp_pkg::BURST_W-1:0] i_count,
    // order select
    input wire logic i_interleave,
    // result
    output logic [psp_pkg::BURST_W-1:0] o_low
);

    always_comb
    begin
        if (i_interleave)
        begin
            o_low = i_start ^ i_count;
        end
        else
        begin
            // wraps inside the burst, carry never reaches the upper address
            o_low = psp_pkg::BURST_W'(i_start + i_count);
        end
    end

endmodule : psp_burst_step

`default_nettype wire

// File: psp_port_control.sv
// Purpose: device-side control of a synchronous pipelined burst sram port
// Assumes: controller pins are synchronous to i_clock; output enable is asynchronous
// Notes: command edge n, data slot between edges n+1 and n+2 for reads and writes
`default_nettype none

module psp_port_control
#(
    parameter int MEM_ADDR_W = 18
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // synchronous control pins
    input wire psp_pkg::psp_ctrl_s i_ctrl,
    // asynchronous output enable
    input wire logic i_output_enable_n,
    // burst-order strap
    input wire logic i_burst_order,
    input wire logic i_burst_order_open,
    // data and parity pins, three signals each
    input wire logic [psp_pkg::DATA_W-1:0] i_dq,
    input wire logic [psp_pkg::LANES-1:0] i_parity_lines,
    output logic [psp_pkg::DATA_W-1:0] o_dq,
    output logic [psp_pkg::LANES-1:0] o_parity_lines,
    output logic o_dq_oe_n
);

    localparam int DEPTH = 1 << MEM_ADDR_W;

    if (MEM_ADDR_W < psp_pkg::BURST_W || MEM_ADDR_W > psp_pkg::ADDR_W)
    begin : g_bad_depth
        $error("MEM_ADDR_W out of range");
    end

    // each lane stores parity above its byte, so parity follows its byte everywhere
    logic [psp_pkg::LANES-1:0][psp_pkg::LANE_W:0] mem [DEPTH];

    psp_pkg::psp_state_s st_reg;
    psp_pkg::psp_state_s st_next;

    logic qualified;
    logic selected;
    logic [psp_pkg::BURST_W-1:0] count_adv;
    logic [psp_pkg::BURST_W-1:0] burst_low;
    logic [psp_pkg::LANES-1:0][psp_pkg::LANE_W:0] pin_lanes;
    logic [psp_pkg::LANES-1:0][psp_pkg::LANE_W:0] rd_lanes;
    logic [psp_pkg::LANES-1:0][psp_pkg::LANE_W:0] fwd_lanes;
    logic [MEM_ADDR_W-1:0] rd_index;
    logic [MEM_ADDR_W-1:0] wr_index;
    logic wr_commit;
    logic fwd_hit;
    logic slot_is_read;

    assign qualified = ~i_ctrl.clock_qualify_n;
    assign selected = ~i_ctrl.chip_select_low_a
                      & i_ctrl.chip_select_high
                      & ~i_ctrl.chip_select_low_c;
    assign count_adv = psp_pkg::BURST_W'(st_reg.burst_count + psp_pkg::BURST_ONE);

    psp_burst_step u_burst_step
    (
        .i_start(st_reg.burst_start),
        .i_count(count_adv),
        .i_interleave(st_reg.mode),
        .o_low(burst_low)
    );

    // pin bits regrouped into lanes of byte plus parity
    always_comb
    begin
        for (int l = 0; l < psp_pkg::LANES; l++)
        begin
            pin_lanes[l] = {i_parity_lines[l], i_dq[l*psp_pkg::LANE_W +: psp_pkg::LANE_W]};
        end
    end

    assign rd_index = st_reg.stage1.addr[MEM_ADDR_W-1:0];
    assign wr_index = st_reg.stage2.addr[MEM_ADDR_W-1:0];
    assign wr_commit = qualified & st_reg.stage2.sel & st_reg.stage2.wr;
    // compare storage indexes: with a shallow array, aliased addresses share one word
    assign fwd_hit = wr_commit & (wr_index == rd_index);
    assign rd_lanes = mem[rd_index];

    // a write landing at the same edge as a read of its address is forwarded,
    // otherwise back-to-back write then read would return stale data
    always_comb
    begin
        for (int l = 0; l < psp_pkg::LANES; l++)
        begin
            if (fwd_hit && !st_reg.stage2.lane_wr_n[l])
            begin
                fwd_lanes[l] = pin_lanes[l];
            end
            else
            begin
                fwd_lanes[l] = rd_lanes[l];
            end
        end
    end

    always_comb
    begin
        st_next = st_reg;
        // strap runs free of clock qualify; it is static in operation
        st_next.mode_sync = {st_reg.mode_sync[0], i_burst_order | i_burst_order_open};
        st_next.mode = st_reg.mode_sync[psp_pkg::SYNC_STAGES-1];
        if (qualified)
        begin
            if (!i_ctrl.advance_or_load)
            begin
                // load a new access; the strobe counts only on a qualified edge
                st_next.stage1.sel = selected;
                st_next.stage1.wr = selected & ~i_ctrl.write_n;
                st_next.stage1.addr = i_ctrl.addr;
                st_next.stage1.lane_wr_n = i_ctrl.byte_lane_write_n;
                st_next.burst_start = i_ctrl.addr[psp_pkg::BURST_W-1:0];
                st_next.burst_count = psp_pkg::BURST_RST;
            end
            else
            begin
                // continue the burst with the same kind of access
                st_next.stage1.addr = {st_reg.stage1.addr[psp_pkg::ADDR_W-1:psp_pkg::BURST_W],
                                       burst_low};
                st_next.stage1.lane_wr_n = i_ctrl.byte_lane_write_n;
                st_next.burst_count = count_adv;
            end
            st_next.stage2 = st_reg.stage1;
            if (st_reg.stage1.sel && !st_reg.stage1.wr)
            begin
                for (int l = 0; l < psp_pkg::LANES; l++)
                begin
                    st_next.rd_word.data[l*psp_pkg::LANE_W +: psp_pkg::LANE_W] =
                        fwd_lanes[l][psp_pkg::LANE_W-1:0];
                    st_next.rd_word.par[l] = fwd_lanes[l][psp_pkg::LANE_W];
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            // synchroniser starts at the reset mode so the order never dips to linear after reset
            st_reg.mode_sync <= {psp_pkg::SYNC_STAGES{psp_pkg::MODE_RST}};
            st_reg.mode <= psp_pkg::MODE_RST;
            st_reg.stage1.sel <= 1'b0;
            st_reg.stage1.wr <= 1'b0;
            st_reg.stage1.addr <= psp_pkg::ADDR_RST;
            st_reg.stage1.lane_wr_n <= psp_pkg::LANE_N_RST;
            st_reg.stage2.sel <= 1'b0;
            st_reg.stage2.wr <= 1'b0;
            st_reg.stage2.addr <= psp_pkg::ADDR_RST;
            st_reg.stage2.lane_wr_n <= psp_pkg::LANE_N_RST;
            st_reg.burst_start <= psp_pkg::BURST_RST;
            st_reg.burst_count <= psp_pkg::BURST_RST;
            st_reg.rd_word.data <= psp_pkg::DATA_RST;
            st_reg.rd_word.par <= psp_pkg::PAR_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // storage has no reset; content is undefined until written
    always_ff @(posedge i_clock)
    begin
        if (wr_commit)
        begin
            for (int l = 0; l < psp_pkg::LANES; l++)
            begin
                if (!st_reg.stage2.lane_wr_n[l])
                begin
                    mem[wr_index][l] <= pin_lanes[l];
                end
            end
        end
    end

    // data slot belongs to a read only when the command two stages back was a selected read;
    // write slots, deselect and the first slot after deselect all fall out as tri-state
    assign slot_is_read = st_reg.stage2.sel & ~st_reg.stage2.wr;

    // output enable is a pure gate here: its documented timing is asynchronous
    assign o_dq_oe_n = i_output_enable_n | ~slot_is_read;
    assign o_dq = st_reg.rd_word.data;
    assign o_parity_lines = st_reg.rd_word.par;

endmodule : psp_port_control

`default_nettype wire

// File: psp_port_control_chk.sv
// Purpose: port checks for psp_port_control
// Assumes: one clock domain, bound to psp_port_control
// Notes: stored data content is judged by the bench
`default_nettype none
module psp_port_control_chk
#(
    parameter int MEM_ADDR_W = 18
)
(
    // clock, reset, control
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire psp_pkg::psp_ctrl_s i_ctrl,
    input wire logic i_output_enable_n,
    input wire logic i_burst_order,
    input wire logic i_burst_order_open,
    // pins
    input wire logic [psp_pkg::DATA_W-1:0] i_dq,
    input wire logic [psp_pkg::LANES-1:0] i_parity_lines,
    input wire logic [psp_pkg::DATA_W-1:0] o_dq,
    input wire logic [psp_pkg::LANES-1:0] o_parity_lines,
    input wire logic o_dq_oe_n
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    logic q;
    logic sel;
    logic ld;
    assign q = !i_ctrl.clock_qualify_n;
    assign ld = q && !i_ctrl.advance_or_load;
    assign sel = !i_ctrl.chip_select_low_a && i_ctrl.chip_select_high && !i_ctrl.chip_select_low_c;
    sequence rd_load;
        ld && sel && i_ctrl.write_n;
    endsequence
    sequence wr_load;
        ld && sel && !i_ctrl.write_n;
    endsequence
    a_oe_gate: assert property (!o_dq_oe_n |-> !i_output_enable_n)
        else $error("pins driven with output enable high");
    a_read_slot: assert property (rd_load ##1 q |=> i_output_enable_n || !o_dq_oe_n)
        else $error("read slot not driven");
    a_write_quiet: assert property (wr_load ##1 q |=> o_dq_oe_n)
        else $error("driven in write data slot");
    a_desel_quiet: assert property (ld && !sel ##1 q |=> o_dq_oe_n)
        else $error("driven after deselect");
    a_third_select: assert property ((ld && i_ctrl.chip_select_low_c ##1 q) |-> ##1 o_dq_oe_n)
        else $error("third select ignored");
    a_stall_data: assert property (!q |=> $stable(o_dq) && $stable(o_parity_lines))
        else $error("data moved on masked edge");
    a_stall_slot: assert property (!q ##1 $stable(i_output_enable_n) |-> $stable(o_dq_oe_n))
        else $error("slot moved on masked edge");
    a_slot_end: assert property ((ld && !(sel && i_ctrl.write_n)) ##1 (q && !o_dq_oe_n) |=> o_dq_oe_n)
        else $error("slot outlived its read");
endmodule : psp_port_control_chk
bind psp_port_control psp_port_control_chk #(.MEM_ADDR_W(MEM_ADDR_W)) psp_port_control_chk_i (.i_clock,
    .i_arst_n, .i_ctrl, .i_output_enable_n, .i_burst_order, .i_burst_order_open, .i_dq, .i_parity_lines,
    .o_dq, .o_parity_lines, .o_dq_oe_n);
`default_nettype wire

// File: psp_ctl_model.sv
// Purpose: external controller side of the data pins
// Assumes: words are handed over with their write command
// Notes: released pins show the inverse of the last level
`default_nettype none
module psp_ctl_model
(
    // bus
    input wire logic i_clock,
    input wire psp_pkg::psp_ctrl_s i_ctrl,
    input wire logic [35:0] i_word,
    // device side
    input wire logic [31:0] i_dev_dq,
    input wire logic [3:0] i_dev_par,
    input wire logic i_dev_oe_n,
    // resolved pins
    output logic [31:0] o_dq,
    output logic [3:0] o_par
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cmd_wr = 1'h0;
    logic drv = 1'h0;
    logic [35:0] pend_w = '0;
    logic [35:0] w = '0;
    logic [35:0] last = '0;
    logic [35:0] pin;
    assign pin = drv ? w : (!i_dev_oe_n ? {i_dev_par, i_dev_dq} : ~last);
    assign o_dq = pin[31:0];
    assign o_par = pin[35:32];
    always @(posedge i_clock)
    begin
        last <= pin;
        // strobe only counts on qualified edges
        if (!i_ctrl.clock_qualify_n)
        begin
            // an advance keeps the last command, so no write after a deselect
            cmd_wr <= i_ctrl.advance_or_load ? cmd_wr : (!i_ctrl.chip_select_low_a && i_ctrl.chip_select_high
                && !i_ctrl.chip_select_low_c && !i_ctrl.write_n);
            drv <= cmd_wr;
            pend_w <= i_word;
            w <= pend_w;
        end
    end
endmodule : psp_ctl_model
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for psp_port_control
// Assumes: inputs change at the falling edge
// Notes: small storage depth keeps the run short
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] SEL = 3'h2;
    localparam psp_pkg::psp_ctrl_s IDLE = {3'h6, 1'h0, 1'h1, 1'h0, 4'hF, 18'h0};
    localparam psp_pkg::psp_ctrl_s STALL = {3'h6, 1'h1, 1'h1, 1'h0, 4'hF, 18'h0};
    logic i_clock = 1'h0;
    logic i_arst_n = 1'h0;
    psp_pkg::psp_ctrl_s ctrl = IDLE;
    logic oe_n = 1'h0;
    logic order = 1'h1;
    logic opn = 1'h0;
    logic [35:0] word = '0;
    logic [31:0] dq_pin;
    logic [31:0] dq_dev;
    logic [3:0] par_pin;
    logic [3:0] par_dev;
    logic dev_oe_n;
    int mismatches = 0;
    int checks_done = 0;
    always #4 i_clock = ~i_clock;
    psp_port_control #(.MEM_ADDR_W(6)) psp_port_control_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
        .i_ctrl(ctrl), .i_output_enable_n(oe_n), .i_burst_order(order), .i_burst_order_open(opn),
        .i_dq(dq_pin), .i_parity_lines(par_pin), .o_dq(dq_dev), .o_parity_lines(par_dev), .o_dq_oe_n(dev_oe_n));
    psp_ctl_model psp_ctl_model_i (.i_clock(i_clock), .i_ctrl(ctrl), .i_word(word), .i_dev_dq(dq_dev),
        .i_dev_par(par_dev), .i_dev_oe_n(dev_oe_n), .o_dq(dq_pin), .o_par(par_pin));
    function automatic psp_pkg::psp_ctrl_s mk(input logic wr_n, input logic adv, input logic [17:0] a,
        input logic [3:0] bw);
        return {SEL, 1'h0, wr_n, adv, bw, a};
    endfunction : mk
    task automatic go(input psp_pkg::psp_ctrl_s c, input logic [35:0] w);
        @(negedge i_clock);
        ctrl = c;
        word = w;
    endtask : go
    task automatic look;
        @(posedge i_clock);
        #1;
    endtask : look
    task automatic rst(input logic o, input logic f);
        @(negedge i_clock);
        i_arst_n = 1'h0;
        order = o;
        opn = f;
        repeat (16) @(negedge i_clock);
        i_arst_n = 1'h1;
        `CHK("reset slot", 1'h1, dev_oe_n)
        repeat (4) @(negedge i_clock);
    endtask : rst
    task automatic t_rw;
        go(mk(1'h0, 1'h0, 18'h5, 4'h0), 36'h9_1234_5678);
        go(mk(1'h0, 1'h0, 18'h5, 4'hD), 36'h6_ABCD_EF01);
        go(mk(1'h1, 1'h0, 18'h5, 4'hF), '0);
        go(IDLE, '0);
        look();
        `CHK("merged word", 36'hB_1234_EF78, {par_dev, dq_dev})
        `CHK("read slot", 1'h0, dev_oe_n)
        go(mk(1'h1, 1'h0, 18'h5, 4'hF), '0);
        oe_n = 1'h1;
        go(IDLE, '0);
        look();
        `CHK("enable high slot", 1'h1, dev_oe_n)
        go(IDLE, '0);
        oe_n = 1'h0;
        $display("done read write");
    endtask : t_rw
    task automatic t_sel;
        for (int i = 0; i < 3; i++)
        begin
            go({SEL ^ (3'h4 >> i), 1'h0, 1'h1, 1'h0, 4'hF, 18'h5}, '0);
            go(IDLE, '0);
            look();
            `CHK("deselected slot", 1'h1, dev_oe_n)
        end
        $display("done select");
    endtask : t_sel
    task automatic t_stall;
        go(mk(1'h0, 1'h0, 18'h9, 4'h0), 36'h3_0F0F_F0F0);
        go(IDLE, '0);
        go(IDLE, '0);
        go(mk(1'h1, 1'h0, 18'h9, 4'hF), '0);
        go(STALL, '0);
        look();
        `CHK("stalled data", 36'hB_1234_EF78, {par_dev, dq_dev})
        go(IDLE, '0);
        look();
        `CHK("resumed data", 36'h3_0F0F_F0F0, {par_dev, dq_dev})
        `CHK("resumed slot", 1'h0, dev_oe_n)
        $display("done stall");
    endtask : t_stall
    task automatic t_burst(input logic o, input logic f);
        logic [1:0] k;
        rst(o, f); // strap only moves under reset
        go(mk(1'h0, 1'h0, 18'h11, 4'h0), 36'hA_0000_0000);
        for (int b = 1; b < 4; b++)
            go(mk(1'h0, 1'h1, 18'h0, 4'h0), 36'hA_0000_0000 + 36'(b));
        go(IDLE, '0);
        go(IDLE, '0);
        for (int l = 0; l < 4; l++)
        begin
            k = (o | f) ? 2'(l) ^ 2'h1 : 2'(l) - 2'h1;
            go(mk(1'h1, 1'h0, 18'h10 + 18'(l), 4'hF), '0);
            go(IDLE, '0);
            look();
            `CHK("burst beat", 36'hA_0000_0000 + 36'(k), {par_dev, dq_dev})
        end
        $display("done burst %0d %0d", o, f);
    endtask : t_burst
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    initial
    begin
        rst(1'h1, 1'h0);
        t_rw();
        t_sel();
        t_stall();
        t_burst(1'h1, 1'h0);
        t_burst(1'h0, 1'h0);
        t_burst(1'h0, 1'h1);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
